// ### hdl/mag_mode_irq_config_regs.sv
`timescale 1ns/1ps
// How it works
// - rate field bits 5:3 picks data rate
// - mode field 00 normal 01 forced 11 sleep
// - advanced self-test control at bits 7:6
// - normal self-test control at bit 0
// - overrun flagged only while its enable set
// - overflow reaches interrupt pin when mapped
// - high-limit axis enables, active low, reset off
// - low-limit axis enables, active low, reset off
// - disabled channel keeps its last value
// - z off stops resistance, forces zero
// - disabled axes still evaluated on held value
// - ready pin driven only when enabled
// - interrupt pin driven only when enabled
// - channel enables bits 5:3, active low
// - ready pin polarity from bit 2
// - latched interrupt holds until status read
// - interrupt pin polarity from bit 0
// - low limit register sets low threshold
// - status layout overrun, overflow, high, low
// - high limit register sets high threshold
module mag_mode_irq_config_regs #(
  parameter int X_W = 13,
  parameter int Z_W = 15,
  parameter int R_W = 14
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [7:0] rd_data_out,
  input wire logic meas_valid_in,
  input wire logic [X_W-1:0] meas_x_in,
  input wire logic [X_W-1:0] meas_y_in,
  input wire logic [Z_W-1:0] meas_z_in,
  input wire logic [R_W-1:0] meas_r_in,
  input wire logic overflow_in,
  input wire logic data_read_in,
  output logic [X_W-1:0] x_data_out,
  output logic [X_W-1:0] y_data_out,
  output logic [Z_W-1:0] z_data_out,
  output logic [R_W-1:0] r_data_out,
  output logic [2:0] chan_enable_out,
  output logic [1:0] op_mode_out,
  output logic [2:0] output_rate_sel_out,
  output logic [4:0] rate_hz_out,
  output logic [1:0] advanced_selftest_ctl_out,
  output logic selftest_out,
  output logic [7:0] low_limit_value_out,
  output logic [7:0] high_limit_value_out,
  output logic data_ready_pin_out,
  output logic irq_pin_out
);

  // configuration registers
  logic [7:0] mode_q; // mode, rate and self-test
  logic [7:0] irq_en_q; // interrupt source enables
  logic [7:0] pin_cfg_q; // pin mapping and channel enables
  logic [7:0] low_lim_q; // low threshold
  logic [7:0] high_lim_q; // high threshold
  logic [7:0] status_q; // interrupt status
  logic [7:0] status_d;
  logic ready_q; // a sample waits unread
  logic [X_W-1:0] x_q;
  logic [X_W-1:0] y_q;
  logic [Z_W-1:0] z_q;
  logic [R_W-1:0] r_q;
  logic [7:0] rd_data_q;
  logic [1:0] op_mode_q;
  logic [4:0] rate_hz_q;
  logic irq_pin_q;
  logic rdy_pin_q;
  logic [2:0] chan_en_q; // channel enables held for the output pins
  logic [2:0] chan_on; // active-high channel enables
  logic [2:0] high_on; // active-high high-limit enables
  logic [2:0] low_on; // active-high low-limit enables
  logic [7:0] cur; // event and condition vector, status layout
  logic [7:0] clr_mask; // bits cleared by a status read
  logic status_rd; // host reads the status register
  logic irq_cond; // interrupt condition before the pin stage

  limit_if lim ();

  // write decode, shared by every writable register process
  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] ofs,
    input logic we);
    return we && (a == ofs);
  endfunction : wr_hit

  // active-low enable fields turned active high
  assign chan_on = ~pin_cfg_q[mag_cfg_pkg::CHAN_DIS_LSB +: 3];
  assign high_on = ~irq_en_q[mag_cfg_pkg::HIGH_EN_LSB +: 3];
  assign low_on = ~irq_en_q[mag_cfg_pkg::LOW_EN_LSB +: 3];
  assign status_rd = rd_en_in && (addr_in == mag_cfg_pkg::STATUS_OFS);

  // mode, rate and self-test register
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      mode_q <= mag_cfg_pkg::MODE_RST;
    end
    else if (wr_hit(addr_in, mag_cfg_pkg::MODE_OFS, wr_en_in))
    begin
      // stored as written so the reserved code still reads back
      mode_q <= wr_data_in;
    end
  end

  // interrupt source enable register
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      irq_en_q <= mag_cfg_pkg::IRQ_EN_RST;
    end
    else if (wr_hit(addr_in, mag_cfg_pkg::IRQ_EN_OFS, wr_en_in))
    begin
      irq_en_q <= wr_data_in;
    end
  end

  // pin mapping and axis enable register
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      pin_cfg_q <= mag_cfg_pkg::PIN_CFG_RST;
    end
    else if (wr_hit(addr_in, mag_cfg_pkg::PIN_CFG_OFS, wr_en_in))
    begin
      pin_cfg_q <= wr_data_in;
    end
  end

  // threshold registers
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      low_lim_q <= mag_cfg_pkg::LOW_LIM_RST;
      high_lim_q <= mag_cfg_pkg::HIGH_LIM_RST;
    end
    else
    begin
      if (wr_hit(addr_in, mag_cfg_pkg::LOW_LIM_OFS, wr_en_in))
        low_lim_q <= wr_data_in;
      if (wr_hit(addr_in, mag_cfg_pkg::HIGH_LIM_OFS, wr_en_in))
        high_lim_q <= wr_data_in;
    end
  end

  // mode decode; the reserved code falls to sleep, the safest choice
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      op_mode_q <= mag_cfg_pkg::OPM_NORMAL;
      rate_hz_q <= mag_cfg_pkg::rate_hz(mag_cfg_pkg::MODE_RST[mag_cfg_pkg::RATE_LSB +: 3]);
    end
    else
    begin
      unique case (mode_q[mag_cfg_pkg::OPM_LSB +: 2])
        mag_cfg_pkg::OPM_NORMAL: op_mode_q <= mag_cfg_pkg::OPM_NORMAL;
        mag_cfg_pkg::OPM_FORCED: op_mode_q <= mag_cfg_pkg::OPM_FORCED;
        mag_cfg_pkg::OPM_SLEEP: op_mode_q <= mag_cfg_pkg::OPM_SLEEP;
        default: op_mode_q <= mag_cfg_pkg::OPM_SLEEP;
      endcase
      rate_hz_q <= mag_cfg_pkg::rate_hz(mode_q[mag_cfg_pkg::RATE_LSB +: 3]);
    end
  end

  // held measurement data; a disabled channel keeps its last sample
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      x_q <= '0;
      y_q <= '0;
      z_q <= '0;
      r_q <= '0;
    end
    else
    begin
      if (meas_valid_in && chan_on[0])
        x_q <= meas_x_in;
      if (meas_valid_in && chan_on[1])
        y_q <= meas_y_in;
      if (meas_valid_in && chan_on[mag_cfg_pkg::AXIS_Z])
        z_q <= meas_z_in;
      // resistance rides on the z channel and reads zero while it is off
      if (!chan_on[mag_cfg_pkg::AXIS_Z])
        r_q <= '0;
      else if (meas_valid_in)
        r_q <= meas_r_in;
    end
  end

  // data ready: set by a sample, cleared when data are read; set wins
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      ready_q <= 1'b0;
    else if (meas_valid_in)
      ready_q <= 1'b1;
    else if (data_read_in)
      ready_q <= 1'b0;
  end

  // threshold comparison works on the held top byte of each axis
  assign lim.axis_msb[0] = x_q[X_W-1 -: mag_cfg_pkg::LIM_W];
  assign lim.axis_msb[1] = y_q[X_W-1 -: mag_cfg_pkg::LIM_W];
  assign lim.axis_msb[2] = z_q[Z_W-1 -: mag_cfg_pkg::LIM_W];
  assign lim.low_lim = low_lim_q;
  assign lim.high_lim = high_lim_q;

  limit_eval #(
    .NUM_AXES(mag_cfg_pkg::NUM_AXES)
  ) u_limit_eval (
    .lim(lim)
  );

  // current events and conditions, laid out like the status register
  always_comb
  begin
    cur = '0;
    cur[mag_cfg_pkg::ST_OVERRUN_BIT] = meas_valid_in && ready_q
      && irq_en_q[mag_cfg_pkg::OVERRUN_EN_BIT];
    cur[mag_cfg_pkg::ST_OVF_BIT] = overflow_in;
    cur[mag_cfg_pkg::ST_HIGH_LSB +: 3] = lim.high_hit & high_on;
    cur[mag_cfg_pkg::ST_LOW_LSB +: 3] = lim.low_hit & low_on;
  end

  // a status read clears latched bits; overrun is an event, so always sticky
  always_comb
  begin
    clr_mask = status_rd ? 8'hFF : 8'h00;
    if (pin_cfg_q[mag_cfg_pkg::LATCH_BIT])
    begin
      status_d = (status_q & ~clr_mask) | cur;
    end
    else
    begin
      // live conditions; only the overrun event needs holding
      status_d = cur;
      status_d[mag_cfg_pkg::ST_OVERRUN_BIT] = cur[mag_cfg_pkg::ST_OVERRUN_BIT]
        | (status_q[mag_cfg_pkg::ST_OVERRUN_BIT] & ~clr_mask[mag_cfg_pkg::ST_OVERRUN_BIT]);
    end
  end

  // status register
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      status_q <= mag_cfg_pkg::STATUS_RST;
    else
      status_q <= status_d;
  end

  // interrupt pin condition: thresholds always, overflow only when mapped
  assign irq_cond = (|status_q[mag_cfg_pkg::ST_HIGH_LSB +: 3])
    || (|status_q[mag_cfg_pkg::ST_LOW_LSB +: 3])
    || (status_q[mag_cfg_pkg::ST_OVF_BIT] && irq_en_q[mag_cfg_pkg::OVF_MAP_BIT]);

  // pin stage; a disabled pin rests at its inactive level
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      irq_pin_q <= 1'b0;
      rdy_pin_q <= 1'b0;
      chan_en_q <= ~mag_cfg_pkg::PIN_CFG_RST[mag_cfg_pkg::CHAN_DIS_LSB +: 3];
    end
    else
    begin
      irq_pin_q <= (irq_cond && pin_cfg_q[mag_cfg_pkg::IRQ_PIN_EN_BIT])
        ~^ pin_cfg_q[mag_cfg_pkg::IRQ_POL_BIT];
      rdy_pin_q <= (ready_q && pin_cfg_q[mag_cfg_pkg::RDY_PIN_EN_BIT])
        ~^ pin_cfg_q[mag_cfg_pkg::RDY_POL_BIT];
      // registered so the enable output comes from a flop, one cycle behind
      chan_en_q <= chan_on;
    end
  end

  // read port; data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rd_data_q <= '0;
    end
    else if (!rd_en_in)
    begin
      rd_data_q <= '0;
    end
    else
    begin
      unique case (addr_in)
        mag_cfg_pkg::STATUS_OFS: rd_data_q <= status_q;
        mag_cfg_pkg::MODE_OFS: rd_data_q <= mode_q;
        mag_cfg_pkg::IRQ_EN_OFS: rd_data_q <= irq_en_q;
        mag_cfg_pkg::PIN_CFG_OFS: rd_data_q <= pin_cfg_q;
        mag_cfg_pkg::LOW_LIM_OFS: rd_data_q <= low_lim_q;
        mag_cfg_pkg::HIGH_LIM_OFS: rd_data_q <= high_lim_q;
        default: rd_data_q <= '0; // unmapped reads as zero
      endcase
    end
  end

  // outputs, all from flip-flops
  assign rd_data_out = rd_data_q;
  assign x_data_out = x_q;
  assign y_data_out = y_q;
  assign z_data_out = z_q;
  assign r_data_out = r_q;
  assign chan_enable_out = chan_en_q;
  assign op_mode_out = op_mode_q;
  assign output_rate_sel_out = mode_q[mag_cfg_pkg::RATE_LSB +: 3];
  assign rate_hz_out = rate_hz_q;
  assign advanced_selftest_ctl_out = mode_q[mag_cfg_pkg::ADVANCED_SELFTEST_CTL_LSB +: 2];
  assign selftest_out = mode_q[mag_cfg_pkg::SELFTEST_BIT];
  assign low_limit_value_out = low_lim_q;
  assign high_limit_value_out = high_lim_q;
  assign data_ready_pin_out = rdy_pin_q;
  assign irq_pin_out = irq_pin_q;

  // checks
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  mode_readback_a: assert property (
    rd_en_in && addr_in == mag_cfg_pkg::MODE_OFS |=> rd_data_out == $past(mode_q))
    else $error("mode register read back wrong");
  rate_decode_a: assert property (
    wr_en_in && addr_in == mag_cfg_pkg::MODE_OFS && wr_data_in[5:3] == 3'h4
    |=> ##1 rate_hz_out == 5'h0F)
    else $error("rate code 100 not decoded to 15 Hz");
  forced_mode_a: assert property (
    mode_q[2:1] == 2'h1 |=> op_mode_out == 2'h1)
    else $error("forced mode not decoded");
  overrun_gate_a: assert property (
    $rose(status_q[mag_cfg_pkg::ST_OVERRUN_BIT]) |-> $past(irq_en_q[7]))
    else $error("overrun flagged while disabled");
  chan_hold_a: assert property (
    meas_valid_in && pin_cfg_q[3] |=> x_data_out == $past(x_data_out))
    else $error("disabled x channel changed");
  r_zero_a: assert property (
    pin_cfg_q[5] |=> r_data_out == '0)
    else $error("resistance not zero with z off");
  irq_pin_off_a: assert property (
    !pin_cfg_q[6] |=> irq_pin_out == !$past(pin_cfg_q[0]))
    else $error("disabled irq pin not at inactive level");
  ready_pin_a: assert property (
    pin_cfg_q[7] && ready_q |=> data_ready_pin_out == $past(pin_cfg_q[2]))
    else $error("ready pin level wrong");
  latch_hold_a: assert property (
    pin_cfg_q[1] && !status_rd |=> (status_q & $past(status_q)) == $past(status_q))
    else $error("latched status lost without read");
endmodule : mag_mode_irq_config_regs

// ### hdl/mag_cfg_pkg.sv
package mag_cfg_pkg;
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // register offsets
  localparam logic [7:0] STATUS_OFS = 8'h4A;
  localparam logic [7:0] MODE_OFS = 8'h4C;
  localparam logic [7:0] IRQ_EN_OFS = 8'h4D;
  localparam logic [7:0] PIN_CFG_OFS = 8'h4E;
  localparam logic [7:0] LOW_LIM_OFS = 8'h4F;
  localparam logic [7:0] HIGH_LIM_OFS = 8'h50;
  // reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] IRQ_EN_RST = 8'h3F;
  localparam logic [7:0] PIN_CFG_RST = 8'h07;
  localparam logic [7:0] LOW_LIM_RST = 8'h00;
  localparam logic [7:0] HIGH_LIM_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  // mode register fields
  localparam int ADVANCED_SELFTEST_CTL_LSB = 6;
  localparam int RATE_LSB = 3;
  localparam int OPM_LSB = 1;
  localparam int SELFTEST_BIT = 0;
  // interrupt enable register fields
  localparam int OVERRUN_EN_BIT = 7;
  localparam int OVF_MAP_BIT = 6;
  localparam int HIGH_EN_LSB = 3;
  localparam int LOW_EN_LSB = 0;
  // pin and axis register fields
  localparam int RDY_PIN_EN_BIT = 7;
  localparam int IRQ_PIN_EN_BIT = 6;
  localparam int CHAN_DIS_LSB = 3;
  localparam int RDY_POL_BIT = 2;
  localparam int LATCH_BIT = 1;
  localparam int IRQ_POL_BIT = 0;
  // status register fields
  localparam int ST_OVERRUN_BIT = 7;
  localparam int ST_OVF_BIT = 6;
  localparam int ST_HIGH_LSB = 3;
  localparam int ST_LOW_LSB = 0;
  // axis bookkeeping: x, y, z in index order
  localparam int NUM_AXES = 3;
  localparam int AXIS_Z = 2;
  localparam int LIM_W = 8;
  // operation modes, gray along normal, forced, sleep
  typedef enum logic [1:0] {
    OPM_NORMAL = 2'h0,
    OPM_FORCED = 2'h1,
    OPM_SLEEP = 2'h3
  } op_mode_t;
  localparam logic [1:0] OPM_RESERVED = 2'h2;

  // output data rate code to rate in hertz
  function automatic logic [4:0] rate_hz(input logic [2:0] code);
    logic [4:0] hz;
    hz = 5'h0A;
    unique case (code)
      3'h0: hz = 5'h0A;
      3'h1: hz = 5'h02;
      3'h2: hz = 5'h06;
      3'h3: hz = 5'h08;
      3'h4: hz = 5'h0F;
      3'h5: hz = 5'h14;
      3'h6: hz = 5'h19;
      3'h7: hz = 5'h1E;
    endcase
    return hz;
  endfunction : rate_hz
endpackage : mag_cfg_pkg

// ### hdl/limit_if.sv
`timescale 1ns/1ps
// top bytes of held axis data, limits and raw threshold hits
interface limit_if;
  logic [2:0][7:0] axis_msb; // signed top byte per axis, x at index 0
  logic [7:0] low_lim; // signed low limit
  logic [7:0] high_lim; // signed high limit
  logic [2:0] low_hit; // value below low limit
  logic [2:0] high_hit; // value above high limit
  modport src (output axis_msb, output low_lim, output high_lim, input low_hit,
    input high_hit);
  modport eval (input axis_msb, input low_lim, input high_lim, output low_hit,
    output high_hit);
endinterface : limit_if

// ### hdl/limit_eval.sv
`timescale 1ns/1ps
module limit_eval #(
  parameter int NUM_AXES = 3
) (
  limit_if.eval lim
);
  // one comparator pair per axis; purely combinational, the caller registers
  genvar g;
  generate
    for (g = 0; g < NUM_AXES; g++)
    begin : g_axis
      // held value keeps being compared even when its channel is off
      assign lim.low_hit[g] = $signed(lim.axis_msb[g]) < $signed(lim.low_lim);
      assign lim.high_hit[g] = $signed(lim.axis_msb[g]) > $signed(lim.high_lim);
    end
  endgenerate
endmodule : limit_eval

// ### dv/mag_host_model.sv
`timescale 1ns/1ps
// host side of the register port: one strobe a cycle, changed just after an edge
module mag_host_model (
  input wire logic clk_in,
  output logic [7:0] addr_out,
  output logic [7:0] wr_data_out,
  output logic wr_en_out,
  output logic rd_en_out,
  input wire logic [7:0] rd_data_in
);
  // bus idle from time zero
  initial
  begin
    addr_out = 8'h00;
    wr_data_out = 8'h00;
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
  end

  // one-cycle write; a reserved mode code never leaves the host
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == mag_cfg_pkg::MODE_OFS && v[2:1] == 2'h2)
    begin
      v[2:1] = 2'h3;
    end
    @(posedge clk_in);
    addr_out <= a;
    wr_data_out <= v;
    wr_en_out <= 1'b1;
    @(posedge clk_in);
    wr_en_out <= 1'b0;
    // stale data flipped so nothing leans on a left-over value
    wr_data_out <= ~v;
  endtask : wr_reg

  // one-cycle read; data taken 1 ns after the edge that follows the strobe, where it stands
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_en_out <= 1'b1;
    @(posedge clk_in);
    rd_en_out <= 1'b0;
    #1;
    d = rd_data_in;
  endtask : rd_reg
endmodule : mag_host_model

// ### dv/mag_mode_irq_config_regs_bench.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module mag_mode_irq_config_regs_bench;
  logic sys_clk_in, reset_n_in, wr_en, rd_en, meas_valid, overflow, data_read;
  logic [7:0] addr, wdata, rd_data, lo_v, hi_v, m, v;
  logic [12:0] mx, my, x_d, y_d, hx, hy;
  logic [14:0] mz, z_d, hz;
  logic [13:0] mr, r_d;
  logic [2:0] chan_en, rate_sel;
  logic [1:0] op_mode, advanced_selftest_ctl;
  logic [4:0] rate_hz;
  logic st, rdy_pin, irq_pin;
  int seed = 11;
  int miscompares = 0;
  int n_tests = 0;
  // expected rate per code, and the three legal mode codes
  logic [4:0] hz_tab [8] = '{5'h0A, 5'h02, 5'h06, 5'h08, 5'h0F, 5'h14, 5'h19, 5'h1E};
  logic [1:0] opm_tab [3] = '{2'h0, 2'h1, 2'h3};

  mag_host_model host (.clk_in(sys_clk_in), .addr_out(addr), .wr_data_out(wdata),
    .wr_en_out(wr_en), .rd_en_out(rd_en), .rd_data_in(rd_data));

  mag_mode_irq_config_regs dut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .addr_in(addr), .wr_data_in(wdata), .wr_en_in(wr_en), .rd_en_in(rd_en),
    .rd_data_out(rd_data), .meas_valid_in(meas_valid), .meas_x_in(mx), .meas_y_in(my),
    .meas_z_in(mz), .meas_r_in(mr), .overflow_in(overflow), .data_read_in(data_read),
    .x_data_out(x_d), .y_data_out(y_d), .z_data_out(z_d), .r_data_out(r_d),
    .chan_enable_out(chan_en), .op_mode_out(op_mode), .output_rate_sel_out(rate_sel),
    .rate_hz_out(rate_hz), .advanced_selftest_ctl_out(advanced_selftest_ctl), .selftest_out(st),
    .low_limit_value_out(lo_v), .high_limit_value_out(hi_v),
    .data_ready_pin_out(rdy_pin), .irq_pin_out(irq_pin));

  // 100 MHz clock
  initial
  begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  // verdict and end of run, shared with the watchdog
  task automatic results();
    $display("checks=%0d mismatches=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  // read one register and compare
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd_reg(a, d);
    `CHK(d, e)
  endtask : rd_chk

  // let registered outputs land; pins trail status by one edge
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : settle

  // one sample pulse from the measurement side
  task automatic sample(input logic [12:0] x, input logic [12:0] y,
    input logic [14:0] z, input logic [13:0] r);
    @(posedge sys_clk_in);
    meas_valid <= 1'b1;
    mx <= x;
    my <= y;
    mz <= z;
    mr <= r;
    @(posedge sys_clk_in);
    meas_valid <= 1'b0;
  endtask : sample

  // pulse that tells the block its data were read
  task automatic data_taken();
    @(posedge sys_clk_in);
    data_read <= 1'b1;
    @(posedge sys_clk_in);
    data_read <= 1'b0;
  endtask : data_taken

  // watchdog: the sequence needs a few hundred cycles at most
  initial
  begin
    #200000;
    miscompares++;
    results();
  end

  initial
  begin
    {meas_valid, overflow, data_read} = 3'h0;
    {mx, my, mz, mr} = '0;
    reset_n_in = 1'b0;
    repeat (3) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    settle(1);
    // reset values, idle pins and an unmapped address
    rd_chk(8'h4C, 8'h00);
    rd_chk(8'h4D, 8'h3F);
    rd_chk(8'h4E, 8'h07);
    rd_chk(8'h4F, 8'h00);
    rd_chk(8'h50, 8'h00);
    rd_chk(8'h4A, 8'h00);
    rd_chk(8'h61, 8'h00);
    `CHK(chan_en, 3'h7)
    `CHK({rdy_pin, irq_pin}, 2'h0)
    `CHK(rate_hz, 5'h0A)
    $display("test defaults done");
    // every rate code, every legal mode, random self-test bits
    for (int i = 0; i < 8; i++)
    begin
      m = {2'($random(seed)), 3'(i), opm_tab[i % 3], 1'($random(seed))};
      host.wr_reg(8'h4C, m);
      settle(3);
      `CHK({rate_sel, rate_hz}, {m[5:3], hz_tab[i]})
      `CHK(op_mode, m[2:1])
      `CHK({advanced_selftest_ctl, st}, {m[7:6], m[0]})
      rd_chk(8'h4C, m);
    end
    $display("test mode done");
    // limit registers with random contents
    m = 8'($random(seed));
    v = 8'($random(seed));
    host.wr_reg(8'h4F, m);
    host.wr_reg(8'h50, v);
    settle(1);
    `CHK({lo_v, hi_v}, {m, v})
    rd_chk(8'h4F, m);
    rd_chk(8'h50, v);
    $display("test limits done");
    // enabled capture, then all channels off: values hold, resistance goes to zero
    sample(13'($random(seed)), 13'($random(seed)), 15'($random(seed)), 14'h1ABC);
    settle(2);
    `CHK({x_d, y_d, z_d, r_d}, {mx, my, mz, 14'h1ABC})
    hx = x_d;
    hy = y_d;
    hz = z_d;
    host.wr_reg(8'h4E, 8'h3F);
    settle(1);
    `CHK(chan_en, 3'h0)
    sample(~hx, ~hy, ~hz, 14'h0155);
    settle(3);
    `CHK({x_d, y_d, z_d}, {hx, hy, hz})
    `CHK(r_d, 14'h0000)
    $display("test channels done");
    // high hit on x kept off while disabled, then seen on a disabled channel
    host.wr_reg(8'h4E, 8'h07);
    sample(13'h0FFF, 13'h0, 15'h0, 14'h0);
    host.wr_reg(8'h4F, 8'h80);
    host.wr_reg(8'h50, 8'h10);
    host.wr_reg(8'h4E, 8'h4F);
    settle(4);
    `CHK(irq_pin, 1'b0)
    host.wr_reg(8'h4D, 8'h37);
    sample(13'h0, 13'h0, 15'h0, 14'h0);
    settle(4);
    `CHK({x_d, irq_pin}, {13'h0FFF, 1'b1})
    host.wr_reg(8'h50, 8'h7F);
    settle(4);
    `CHK(irq_pin, 1'b1)
    rd_chk(8'h4A, 8'h08);
    settle(4);
    `CHK(irq_pin, 1'b0)
    host.wr_reg(8'h4E, 8'h4E);
    settle(4);
    `CHK(irq_pin, 1'b1)
    // low hit on z (top byte 0 below 1), active-low pin
    host.wr_reg(8'h4F, 8'h01);
    host.wr_reg(8'h4D, 8'h3B);
    settle(4);
    `CHK(irq_pin, 1'b0)
    rd_chk(8'h4A, 8'h04);
    $display("test thresholds done");
    // ready pin and overrun flag
    host.wr_reg(8'h4D, 8'hBF);
    host.wr_reg(8'h4E, 8'h85);
    data_taken();
    settle(4);
    `CHK(rdy_pin, 1'b0)
    sample(13'($random(seed)), 13'($random(seed)), 15'($random(seed)), 14'h0);
    settle(4);
    `CHK(rdy_pin, 1'b1)
    sample(13'h0, 13'h0, 15'h0, 14'h0);
    rd_chk(8'h4A, 8'h80);
    host.wr_reg(8'h4E, 8'h81);
    settle(4);
    `CHK(rdy_pin, 1'b0)
    data_taken();
    settle(4);
    `CHK(rdy_pin, 1'b1)
    host.wr_reg(8'h4D, 8'h3F);
    sample(13'h0, 13'h0, 15'h0, 14'h0);
    sample(13'h0, 13'h0, 15'h0, 14'h0);
    rd_chk(8'h4A, 8'h00);
    host.wr_reg(8'h4E, 8'h05);
    settle(4);
    `CHK(rdy_pin, 1'b0)
    $display("test ready done");
    // overflow reaches the pin only while mapped, non-latched
    host.wr_reg(8'h4E, 8'h41);
    host.wr_reg(8'h4D, 8'h7F);
    @(posedge sys_clk_in);
    overflow <= 1'b1;
    settle(5);
    `CHK(irq_pin, 1'b1)
    host.wr_reg(8'h4D, 8'h3F);
    settle(5);
    `CHK(irq_pin, 1'b0)
    @(posedge sys_clk_in);
    overflow <= 1'b0;
    $display("test overflow done");
    results();
  end
endmodule : mag_mode_irq_config_regs_bench
